// ### tb/wtu_watchdog_props.sv
`timescale 1ns/10ps
module wtu_watchdog_props
#(
    parameter ADDR_W = 8
)
(
    // Bus side
    input wire clk,
    input wire nrst,
    input wire hsel,
    input wire [ADDR_W-1:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    input wire reg_clk_enable,
    // Watchdog side
    input wire wd_irq,
    input wire wd_reset_req
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    wire req = hsel && hready && htrans[1];
    wire acc = req && reg_clk_enable;
    sequence rd_s;
        acc && !hwrite;
    endsequence
    sequence wait_s;
        !hreadyout ##1 hreadyout;
    endsequence
    read_wait_a: assert property (rd_s |=> wait_s)
        else $error("read wait state wrong");
    gated_bus_a: assert property (req && !reg_clk_enable |=> hreadyout)
        else $error("gated access stalled");
    feed_zero_a: assert property (acc && !hwrite && haddr == 8'h0C |-> ##2 hrdata == 32'h0)
        else $error("feed read not zero");
    upper_zero_a: assert property (rd_s |-> ##2 hrdata[31:8] == 24'h0)
        else $error("upper read bits set");
    bus_okay_a: assert property (acc |=> !hresp [*2])
        else $error("error response");
    rst_pulse_a: assert property (wd_reset_req |=> !wd_reset_req [*8])
        else $error("reset pulse too long");
    irq_hold_a: assert property (wd_irq && !acc && !$past(acc) && !$past(acc, 2) |=> wd_irq)
        else $error("flag lost without write");
    mode_excl_a: assert property (wd_irq |-> !wd_reset_req)
        else $error("reset in interrupt mode");
endmodule // wtu_watchdog_props

// ### tb/wtu_watchdog_test.sv
`timescale 1ns/10ps
module wtu_watchdog_test;
    reg clk = 0;
    reg nrst = 0;
    reg hsel = 0;
    reg [7:0] haddr = 8'h00;
    reg [1:0] htrans = 2'h0;
    reg hwrite = 0;
    reg [31:0] hwdata = 32'h0;
    reg reg_clk_enable = 1;
    reg [2:0] osc = 3'h0;
    reg wt = 0;
    reg [31:0] exp_q[$];
    wire [31:0] hrdata;
    wire hreadyout, hresp, wd_irq, wd_reset_req;
    integer miscompares = 0;
    integer samples_checked = 0;
    integer rst_cnt = 0;
    integer n, i, p, t, tc;

    always #25 clk = ~clk;
    // Free-running sources, unrelated to clk
    always #100 osc[0] = ~osc[0];
    always #170 osc[1] = ~osc[1];
    always #230 osc[2] = ~osc[2];

    wtu_watchdog u_wtu_watchdog (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .reg_clk_enable(reg_clk_enable),
        .internal_high_speed_osc(osc[0]), .internal_low_speed_osc(osc[1]),
        .external_low_speed_crystal(osc[2]), .wd_irq(wd_irq), .wd_reset_req(wd_reset_req));

    task chk(input [31:0] got, input [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp)
            begin
                miscompares = miscompares + 1;
                $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask

    // --------
    // Bus cycles
    // --------
    task bus(input w, input [7:0] a, input [31:0] d);
        begin
            @(negedge clk);
            hsel = 1;
            htrans = 2'h2;
            hwrite = w;
            haddr = a;
            @(negedge clk);
            hsel = 0;
            htrans = 2'h0;
            hwdata = d;
            @(negedge clk);
        end
    endtask

    task wr(input [7:0] a, input [31:0] d);
        bus(1, a, d);
    endtask

    task rd(input [7:0] a, input [31:0] e);
        begin
            exp_q.push_back(e);
            bus(0, a, 32'h0);
        end
    endtask

    // Read data is due once the wait state ends; sampled where settled
    always @(negedge clk)
    begin
        if (wt && hreadyout)
            chk(hrdata, exp_q.pop_front());
        wt = !hreadyout;
        if (wd_reset_req === 1'b1)
            rst_cnt = rst_cnt + 1;
    end

    // Window allows for sync delay and source phase
    task ev(input integer lo, input integer hi, input want);
        begin
            n = 0;
            while (!(wd_irq || wd_reset_req) && n < hi + 20)
            begin
                @(negedge clk);
                n = n + 1;
            end
            chk(n >= lo && n <= hi, 1);
            chk(wd_reset_req, want);
        end
    endtask

    task summarize;
        begin
            $display("checked=%0d miscompares=%0d", samples_checked, miscompares);
            if (miscompares == 0 && samples_checked > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask

    initial
    begin
        #1000000;
        miscompares = miscompares + 1;
        summarize;
    end

    initial
    begin
        n = $urandom(42762);
        repeat (20) @(negedge clk);
        nrst = 1;
        repeat (3) @(negedge clk);
        rd(8'h00, 0);
        rd(8'h08, 32'hFF);
        rd(8'h0C, 0);
        rd(8'h10, 0);
        for (i = 0; i < 4; i = i + 1)
        begin
            wr(8'h04, i);
            rd(8'h04, i);
        end
        wr(8'h0C, 32'h55AA);
        rd(8'h0C, 0);
        wr(8'h00, 32'h4);
        rd(8'h00, 0);
        $display("test registers done");
        tc = 2 + $urandom % 6;
        t = 128 * (tc + 1);
        wr(8'h04, 1);
        wr(8'h08, tc);
        wr(8'h00, 3);
        ev(t - 3, t + 3, 0);
        rd(8'h00, 7);
        wr(8'h00, 5);
        repeat (2) @(negedge clk);
        chk(wd_irq, 0);
        wr(8'h0C, 32'h55AA);
        wr(8'h00, 3);
        repeat (2) @(negedge clk);
        chk(wd_irq, 0);
        $display("test interrupt done");
        repeat (4)
        begin
            repeat (t / 2) @(negedge clk);
            wr(8'h0C, 32'h55AA);
        end
        chk(wd_irq, 0);
        wr(8'h0C, 32'hAA55);
        ev(t - 8, t + 3, 0);
        wr(8'h0C, 32'h55AA);
        // Disable but keep the flag, so the reset-mode clear is visible
        wr(8'h00, 32'h4);
        $display("test feed done");
        wr(8'h08, 0);
        wr(8'h00, 32'h5);
        ev(125, 131, 1);
        rd(8'h00, 1);
        wr(8'h00, 0);
        $display("test reset mode done");
        for (i = 0; i < 3; i = i + 1)
        begin
            p = (i == 0) ? 200 : (i == 1) ? 340 : 460;
            t = 128 * p / 50;
            wr(8'h04, i ? i + 1 : 0);
            wr(8'h00, 3);
            ev(t - 3 * p / 50 - 8, t + 3 * p / 50 + 8, 0);
            wr(8'h0C, 32'h55AA);
            wr(8'h00, 0);
        end
        $display("test sources done");
        reg_clk_enable = 0;
        wr(8'h08, $urandom | 32'h1);
        bus(0, 8'h08, 32'h0);
        reg_clk_enable = 1;
        rd(8'h08, 0);
        wr(8'h04, 1);
        wr(8'h00, 3);
        repeat (60) @(negedge clk);
        wr(8'h00, 0);
        repeat (300) @(negedge clk);
        chk(wd_irq, 0);
        chk(rst_cnt, 1);
        $display("test gate and disable done");
        summarize;
    end
endmodule // wtu_watchdog_test

bind wtu_watchdog wtu_watchdog_props #(.ADDR_W(ADDR_W)) u_wtu_watchdog_props (
    .clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .reg_clk_enable(reg_clk_enable), .wd_irq(wd_irq),
    .wd_reset_req(wd_reset_req));

// ### verilog/wtu_defs.vh
`ifndef WTU_DEFS_VH
`define WTU_DEFS_VH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define WTU_OFS_CONFIG 8'h00
`define WTU_OFS_COUNT_CLOCK_SELECT 8'h04
`define WTU_OFS_TC 8'h08
`define WTU_OFS_FEED 8'h0C

// ----------------------------------------
// Field positions
// ----------------------------------------
`define WTU_BIT_EN 0
`define WTU_BIT_IE 1
`define WTU_BIT_FLAG 2
`define WTU_COUNT_CLOCK_SELECT_W 2
`define WTU_TC_W 8
`define WTU_FEED_W 16

// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define WTU_TC_RESET 8'hFF
`define WTU_COUNT_CLOCK_SELECT_RESET 2'h0
`define WTU_FEED_KEY 16'h55AA
`define WTU_SRC_HS_OSC 2'h0
`define WTU_SRC_BUS_CLK 2'h1
`define WTU_SRC_LS_OSC 2'h2
`define WTU_SRC_LS_XTAL 2'h3

// ----------------------------------------
// Counting constants
// ----------------------------------------
`define WTU_PRESC_DIV 128
`define WTU_PRESC_W 7
`define WTU_PRESC_LAST 7'h7F
`define WTU_CNT_W 9
`define WTU_CNT_MIN 9'h001

`endif

// ### verilog/wtu_edge_sync.v
`timescale 1ns/10ps

// Two-flop synchroniser plus rising edge pulse
module wtu_edge_sync
(
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Asynchronous level
    input wire async_in,
    // One-cycle pulse on each rising edge
    output wire rise
);

reg meta_q;
reg sync_q;
reg last_q;

always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        meta_q <= 1'b0;
        sync_q <= 1'b0;
        last_q <= 1'b0;
    end
    else
    begin
        meta_q <= async_in;
        sync_q <= meta_q;
        last_q <= sync_q;
    end
end

assign rise = sync_q & ~last_q;

endmodule // wtu_edge_sync

// ### verilog/wtu_watchdog.v
//
// Contract
// [RULE1] Divide count clock by 128, decrement counter
// [RULE2] Countdown minimum one, interval 128 to 32768
// [RULE3] Enable loads constant; clearing enable stops
// [RULE4] Reset mode underflow resets the processor
// [RULE5] Feed key 0x55AA reloads the counter
// [RULE6] Feed register always reads zero
// [RULE7] Software configures in order, feeds periodically
// [RULE8] Bus clock for registers, separate count clock
// [RULE9] Two-bit source select, resets to 00
// [RULE10] Interrupt only when flag and mode set
// [RULE11] Interrupt mode underflow sets bit 2
// [RULE12] Software feeds before clearing the flag
// [RULE13] Mode 0 resets and clears flag; 1 interrupts
// [RULE14] Constant resets 0xFF, effective value plus one
// [RULE15] Timeout whenever enabled and clock running
// [RULE16] Gated bus clock makes registers unreachable
// [RULE17] Cross-domain events are synchronised
//
`timescale 1ns/10ps
`include "wtu_defs.vh"

module wtu_watchdog
#(
    parameter ADDR_W = 8,
    parameter PRESC_W = `WTU_PRESC_W,
    parameter CNT_W = `WTU_CNT_W
)
(
    // Clock and reset
    input wire clk,
    input wire nrst,
    // AHB-Lite slave
    input wire hsel,
    input wire [ADDR_W-1:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    // Register clock gate from system control
    input wire reg_clk_enable,
    // Count clock sources
    input wire internal_high_speed_osc,
    input wire internal_low_speed_osc,
    input wire external_low_speed_crystal,
    // Watchdog outputs
    output reg wd_irq,
    output reg wd_reset_req
);

// ----------------------------------------
// Reset release
// ----------------------------------------
reg rst_meta_q;
reg rst_n_q;

always @(posedge clk or negedge nrst)
begin
    if (!nrst)
    begin
        rst_meta_q <= 1'b0;
        rst_n_q <= 1'b0;
    end
    else
    begin
        rst_meta_q <= 1'b1;
        rst_n_q <= rst_meta_q;
    end
end

// ----------------------------------------
// Count clock sources
// ----------------------------------------
// Oscillators are sampled, so each must run below half of clk
wire hs_rise;
wire ls_rise;
wire xtal_rise;

wtu_edge_sync u_sync_hs
(
    .clk(clk),
    .rst_n(rst_n_q),
    .async_in(internal_high_speed_osc),
    .rise(hs_rise)
); // RULE17

wtu_edge_sync u_sync_ls
(
    .clk(clk),
    .rst_n(rst_n_q),
    .async_in(internal_low_speed_osc),
    .rise(ls_rise)
); // RULE17

wtu_edge_sync u_sync_xtal
(
    .clk(clk),
    .rst_n(rst_n_q),
    .async_in(external_low_speed_crystal),
    .rise(xtal_rise)
); // RULE17

// ----------------------------------------
// Register state
// ----------------------------------------
reg wd_enable_bit_q;
reg wd_interrupt_mode_bit_q;
reg wd_timeout_flag_q;
reg [`WTU_COUNT_CLOCK_SELECT_W-1:0] count_clock_select_q;
reg [`WTU_TC_W-1:0] timer_constant_q;

// ----------------------------------------
// Bus address phase
// ----------------------------------------
wire acc;
reg wr_q;
reg rd_q;
reg [ADDR_W-1:0] addr_q;

// Accesses are dropped while the register clock is gated
assign acc = hsel & hready & htrans[1] & reg_clk_enable; // RULE16

always @(posedge clk or negedge rst_n_q)
begin
    if (!rst_n_q)
    begin
        wr_q <= 1'b0;
        rd_q <= 1'b0;
        addr_q <= {ADDR_W{1'b0}};
    end
    else
    begin
        wr_q <= acc & hwrite;
        rd_q <= acc & ~hwrite;
        if (acc)
        begin
            addr_q <= haddr;
        end
    end
end

// ----------------------------------------
// Write decode (data phase)
// ----------------------------------------
wire wr_cfg;
wire wr_sel;
wire wr_tc;
wire feed_hit;
wire flag_clr;

assign wr_cfg = wr_q & (addr_q == `WTU_OFS_CONFIG);
assign wr_sel = wr_q & (addr_q == `WTU_OFS_COUNT_CLOCK_SELECT);
assign wr_tc = wr_q & (addr_q == `WTU_OFS_TC);
assign feed_hit = wr_q & (addr_q == `WTU_OFS_FEED)
    & (hwdata[`WTU_FEED_W-1:0] == `WTU_FEED_KEY); // RULE5
assign flag_clr = wr_cfg & ~hwdata[`WTU_BIT_FLAG]; // RULE11

always @(posedge clk or negedge rst_n_q)
begin
    if (!rst_n_q)
    begin
        wd_enable_bit_q <= 1'b0;
        wd_interrupt_mode_bit_q <= 1'b0;
        count_clock_select_q <= `WTU_COUNT_CLOCK_SELECT_RESET; // RULE9
        timer_constant_q <= `WTU_TC_RESET; // RULE14
    end
    else
    begin
        if (wr_cfg)
        begin
            wd_enable_bit_q <= hwdata[`WTU_BIT_EN]; // RULE3
            wd_interrupt_mode_bit_q <= hwdata[`WTU_BIT_IE];
        end
        if (wr_sel)
        begin
            count_clock_select_q <= hwdata[`WTU_COUNT_CLOCK_SELECT_W-1:0];
        end
        if (wr_tc)
        begin
            timer_constant_q <= hwdata[`WTU_TC_W-1:0];
        end
    end
end

// ----------------------------------------
// Read path
// ----------------------------------------
// One wait state so a write just before a read is visible
reg [31:0] rdata_d;

always @*
begin
    rdata_d = 32'h0000_0000;
    case (addr_q)
        `WTU_OFS_CONFIG:
        begin
            rdata_d[`WTU_BIT_EN] = wd_enable_bit_q;
            rdata_d[`WTU_BIT_IE] = wd_interrupt_mode_bit_q;
            rdata_d[`WTU_BIT_FLAG] = wd_timeout_flag_q;
        end
        `WTU_OFS_COUNT_CLOCK_SELECT:
        begin
            rdata_d[`WTU_COUNT_CLOCK_SELECT_W-1:0] = count_clock_select_q;
        end
        `WTU_OFS_TC:
        begin
            rdata_d[`WTU_TC_W-1:0] = timer_constant_q;
        end
        `WTU_OFS_FEED:
        begin
            rdata_d = 32'h0000_0000; // RULE6
        end
        default:
        begin
            rdata_d = 32'h0000_0000;
        end
    endcase
end

always @(posedge clk or negedge rst_n_q)
begin
    if (!rst_n_q)
    begin
        hrdata <= 32'h0000_0000;
        hreadyout <= 1'b1;
        hresp <= 1'b0;
    end
    else
    begin
        hresp <= 1'b0;
        if (acc & ~hwrite)
        begin
            hreadyout <= 1'b0;
        end
        else if (rd_q)
        begin
            hrdata <= rdata_d;
            hreadyout <= 1'b1;
        end
    end
end

// ----------------------------------------
// Count clock selection
// ----------------------------------------
reg tick;

// Counting sees only ticks of the chosen source
always @*
begin
    case (count_clock_select_q) // RULE9 RULE8
        `WTU_SRC_HS_OSC: tick = hs_rise;
        `WTU_SRC_BUS_CLK: tick = 1'b1;
        `WTU_SRC_LS_OSC: tick = ls_rise;
        `WTU_SRC_LS_XTAL: tick = xtal_rise;
        default: tick = 1'b0;
    endcase
end

// ----------------------------------------
// Prescaler and down counter
// ----------------------------------------
localparam [PRESC_W-1:0] PRESC_LAST = `WTU_PRESC_LAST;

reg en_last_q;
reg [PRESC_W-1:0] presc_q;
reg [CNT_W-1:0] cnt_q;
wire start;
wire load;
wire presc_wrap;
wire underflow;
wire [CNT_W-1:0] reload;

assign start = wd_enable_bit_q & ~en_last_q; // RULE3
assign load = start | (feed_hit & wd_enable_bit_q); // RULE5
assign reload = {1'b0, timer_constant_q} + `WTU_CNT_MIN; // RULE14
assign presc_wrap = tick & (presc_q == PRESC_LAST); // RULE1
assign underflow = wd_enable_bit_q & ~load & presc_wrap
    & (cnt_q == `WTU_CNT_MIN); // RULE2 RULE15

always @(posedge clk or negedge rst_n_q)
begin
    if (!rst_n_q)
    begin
        en_last_q <= 1'b0;
        presc_q <= {PRESC_W{1'b0}};
        cnt_q <= {CNT_W{1'b0}};
    end
    else
    begin
        en_last_q <= wd_enable_bit_q;
        if (!wd_enable_bit_q)
        begin
            // Disabled: prescaler cleared, counter frozen
            presc_q <= {PRESC_W{1'b0}}; // RULE3
        end
        else if (load)
        begin
            presc_q <= {PRESC_W{1'b0}};
            cnt_q <= reload;
        end
        else if (tick)
        begin
            presc_q <= presc_q + 1'b1; // RULE1
            if (presc_wrap)
            begin
                if (underflow)
                begin
                    cnt_q <= reload;
                end
                else
                begin
                    cnt_q <= cnt_q - 1'b1; // RULE1
                end
            end
        end
    end
end

// ----------------------------------------
// Timeout flag and outputs
// ----------------------------------------
// Hardware set wins over a software clear in the same cycle
always @(posedge clk or negedge rst_n_q)
begin
    if (!rst_n_q)
    begin
        wd_timeout_flag_q <= 1'b0;
        wd_irq <= 1'b0;
        wd_reset_req <= 1'b0;
    end
    else
    begin
        if (underflow & wd_interrupt_mode_bit_q)
        begin
            wd_timeout_flag_q <= 1'b1; // RULE11 RULE13
        end
        else if (underflow)
        begin
            wd_timeout_flag_q <= 1'b0; // RULE13
        end
        else if (flag_clr)
        begin
            wd_timeout_flag_q <= 1'b0; // RULE11
        end
        wd_irq <= wd_timeout_flag_q & wd_interrupt_mode_bit_q; // RULE10
        // Pulse drives the processor reset like the external pin
        wd_reset_req <= underflow & ~wd_interrupt_mode_bit_q; // RULE4 RULE13
    end
end

endmodule // wtu_watchdog
